//--- verilog/usb_pipe_config.v
// Behaviour
// - With the end-of-transfer NAK option set on a receiving pipe, the response control drops to NAK at transfer end.
// - That option only acts on pipes one to five while they are set to receive.
// - A short packet received without error, zero length included, ends a receive transfer.
// - With the transaction counter in use, receiving the counted number of good packets also ends the transfer.
// - Direction value zero makes the pipe receive and value one makes it transmit.
// - The endpoint number names the endpoint served, and an all-zero endpoint marks the pipe unused.
// - The size field in bits 14 to 10 sets the FIFO size of pipes one to five in 64-byte steps from 64 bytes up to 2 Kbytes.
// - The start-block field gives the first FIFO block of the pipe, accepted from 0x4 to 0x87 on pipes one to five.
// - With double-sided mode set, the pipe gets (size+1)*64*(double+1) bytes.
`timescale 1ns/1ps
`include "usb_pipe_config_map.vh"
module usb_pipe_config (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        ce,
  input  wire [7:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire        rx_done,
  input  wire [3:0]  rx_pipe,
  input  wire        rx_ok,
  input  wire        rx_short,
  input  wire [9:0]  pipe_busy_flag,
  input  wire        split_control_status,
  input  wire [3:0]  current_pipe_select,
  input  wire [3:0]  link_pipe,
  output reg         link_dir,
  output reg  [3:0]  link_endpoint_number_field,
  output reg         link_in_use,
  output reg  [1:0]  link_response,
  output reg  [7:0]  link_fifo_start,
  output reg  [7:0]  link_fifo_last,
  output reg  [12:0] link_fifo_bytes
);

  // Per-pipe storage; index 0 is the control pipe and is not held here.
  // Arrays are indexed by pipe number, so the register side and the engine share one decode.
  // Every read of them sits behind a range check, which keeps unknowns from empty slots out.
  reg [9:0] cfg      [1:9];
  reg [4:0] size     [1:9];
  reg [7:0] start    [1:9];
  reg [1:0] resp     [1:9];
  reg       ended    [1:9];
  reg [7:0] trn_goal [1:9];
  reg [7:0] trn_seen [1:9];
  reg [3:0] selected_pipe_index;
  // One loop variable per process, so no variable has two drivers.
  integer   i;
  integer   j;

  // True for pipes that hold a configuration copy.
  // Index 0 belongs to the control pipe, and 10 to 15 name no pipe at all.
  function is_pipe;
    input [3:0] p;
    begin
      is_pipe = (p >= `PIPE_FIRST) && (p <= `PIPE_LAST);
    end
  endfunction

  // Pipes one to five carry the full option set.
  // The fixed pipes have single-block FIFOs and no transfer-end logic behind their option bits.
  function is_auto_pipe;
    input [3:0] p;
    begin
      is_auto_pipe = (p >= `PIPE_FIRST) && (p <= `PIPE_LAST_AUTO);
    end
  endfunction

  // Write to one register offset; the valid input lets per-pipe registers refuse a bad select.
  function pipe_write;
    input       strobe;
    input       valid;
    input [7:0] a;
    input [7:0] ofs;
    begin
      pipe_write = strobe && valid && (a == ofs);
    end
  endfunction

  // Allocated bytes; the double flag only counts where the pipe supports it.
  // The largest result, 32 blocks doubled, is 4096 bytes, so 13 bits hold every case.
  function [12:0] fifo_bytes;
    input [4:0] sz;
    input       dbl;
    reg   [13:0] b;
    begin
      b = ({9'h000, sz} + 14'h0001) * `FIFO_BLOCK_BYTES;
      if (dbl)
        b = b << 1;
      fifo_bytes = b[12:0];
    end
  endfunction

  // Blocks allocated, used to report the last block of the pipe.
  // At most 64 blocks, so the count never carries into the top bit of the result.
  function [7:0] fifo_blocks;
    input [4:0] sz;
    input       dbl;
    reg   [6:0] n;
    begin
      n = {2'h0, sz} + 7'h01;
      if (dbl)
        n = n << 1;
      fifo_blocks = {1'h0, n};
    end
  endfunction

  // Selected-pipe qualifiers for the register side.
  wire       sel_ok   = is_pipe(selected_pipe_index);
  wire       sel_auto = is_auto_pipe(selected_pipe_index);
  // Receive event decode; errored packets and unknown pipe numbers never reach the state below.
  // A transmit pipe only reads its direction here, so packets aimed at it change nothing.
  // The count only moves on good packets, so an errored retry never shortens a counted transfer.
  wire       rx_valid = rx_done && rx_ok && is_pipe(rx_pipe);
  wire [9:0] rx_cfg   = rx_valid ? cfg[rx_pipe] : `RST_CONFIG;
  wire       rx_recv  = rx_cfg[`CFG_DIR_BIT] == `DIR_RECEIVE;
  wire [7:0] rx_next  = rx_valid ? trn_seen[rx_pipe] + 8'h01 : 8'h00;
  // A short packet or the last counted packet closes the transfer.
  // A zero-length packet counts as short, which is how a host ends a transfer on a packet boundary.
  wire       rx_end   = rx_valid && rx_recv &&
                        (rx_short ||
                         (rx_cfg[`CFG_TRN_EN_BIT] && rx_next == trn_goal[rx_pipe]));
  // Auto NAK only where the option exists and the pipe receives.
  // The NAK lands on the same edge as the end flag, so the next token already sees it.
  wire       rx_nak   = rx_end && rx_cfg[`CFG_NAK_EN_BIT] && is_auto_pipe(rx_pipe);
  // Write decodes; the select register is global, the rest act on the selected pipe only.
  // Decodes ignore the clock enable; every process that uses them is gated by it.
  wire       w_sel    = pipe_write(wr, 1'b1, addr, `OFS_PIPE_SELECT);
  wire       w_cfg    = pipe_write(wr, sel_ok, addr, `OFS_PIPE_CONFIG);
  wire       w_lay    = pipe_write(wr, sel_ok, addr, `OFS_PIPE_LAYOUT);
  wire       w_rsp    = pipe_write(wr, sel_ok, addr, `OFS_PIPE_RESPONSE);
  wire       w_trn    = pipe_write(wr, sel_ok, addr, `OFS_PIPE_TRN);
  wire [7:0] w_start  = wdata[`LAY_START_MSB:`LAY_START_LSB];
  wire       start_in = w_start >= `LAY_START_MIN && w_start <= `LAY_START_MAX;

  // Pipe select register; out-of-range indexes simply select nothing.
  // Software can park the index on pipe 0 so that no pipe register answers while it works elsewhere.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      selected_pipe_index <= `RST_SELECT;
    end else if (ce && w_sel) begin
      selected_pipe_index <= wdata[`SEL_INDEX_MSB:`SEL_INDEX_LSB];
    end
  end

  // Configuration copies, one per pipe; only the selected pipe is written.
  // Field-by-field writes let the fixed pipes force their option bits without a read-modify-write.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (i = 1; i <= 9; i = i + 1) begin
        cfg[i]      <= `RST_CONFIG;
        size[i]     <= `RST_SIZE;
        start[i]    <= `RST_START;
        trn_goal[i] <= `RST_TRN;
      end
    end else if (ce) begin
      if (w_cfg) begin
        cfg[selected_pipe_index][`CFG_ENDPOINT_NUMBER_FIELD_MSB:`CFG_ENDPOINT_NUMBER_FIELD_LSB] <= wdata[`CFG_ENDPOINT_NUMBER_FIELD_MSB:`CFG_ENDPOINT_NUMBER_FIELD_LSB];
        cfg[selected_pipe_index][`CFG_DIR_BIT] <= wdata[`CFG_DIR_BIT];
        // Options without hardware behind them on pipes six to nine stay zero.
        cfg[selected_pipe_index][`CFG_NAK_EN_BIT] <= sel_auto & wdata[`CFG_NAK_EN_BIT];
        cfg[selected_pipe_index][`CFG_TRN_EN_BIT] <= sel_auto & wdata[`CFG_TRN_EN_BIT];
        cfg[selected_pipe_index][`CFG_DBL_BIT]    <= sel_auto & wdata[`CFG_DBL_BIT];
      end
      // Fixed pipes keep the minimum size; start block writes outside range are dropped.
      // Dropping a bad start keeps the old layout instead of pointing the pipe at the control pipe's blocks.
      if (w_lay) begin
        if (sel_auto)
          size[selected_pipe_index] <= wdata[`LAY_SIZE_MSB:`LAY_SIZE_LSB];
        if (sel_auto && start_in)
          start[selected_pipe_index] <= w_start;
      end
      // A new goal also restarts the packet count in the response process.
      if (w_trn)
        trn_goal[selected_pipe_index] <= wdata[`TRN_GOAL_MSB:`TRN_GOAL_LSB];
    end
  end

  // Response control, packet count and transfer-ended flag.
  // Hardware NAK and the ended flag win over a software write in the same cycle.
  // The count restarts at every transfer end, whether a short packet or the goal closed it.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (j = 1; j <= 9; j = j + 1) begin
        resp[j]     <= `RSP_NAK;
        ended[j]    <= 1'h0;
        trn_seen[j] <= `RST_TRN;
      end
    end else if (ce) begin
      if (w_rsp) begin
        resp[selected_pipe_index] <= wdata[`RSP_CTRL_MSB:`RSP_CTRL_LSB];
        if (wdata[`RSP_ENDED_BIT])
          ended[selected_pipe_index] <= 1'h0;
      end
      if (w_trn)
        trn_seen[selected_pipe_index] <= 8'h00;
      if (rx_valid && rx_recv)
        trn_seen[rx_pipe] <= rx_end ? 8'h00 : rx_next;
      if (rx_end)
        ended[rx_pipe] <= 1'h1;
      if (rx_nak)
        resp[rx_pipe] <= `RSP_NAK;
    end
  end

  // Fixed pipes six to nine own a dedicated start block.
  // Their blocks sit at 0x04 to 0x07, right above the four blocks of the control pipe.
  // Start writes on them are dropped, so the stored value is never consulted there.
  function [7:0] eff_start;
    input [3:0] p;
    input [7:0] s;
    begin
      if (p >= `PIPE_FIRST_FIXED)
        eff_start = `LAY_START_MIN + {4'h0, p - `PIPE_FIRST_FIXED};
      else
        eff_start = s;
    end
  endfunction

  // Each offset reads one 16-bit word, and bits not listed below always read as zero.
  // The select word carries the pipe index in bits 3 to 0.
  // The config word holds endpoint, direction, auto-NAK, counter enable and double FIFO in bits 3 to 0, 4, 7, 8 and 9.
  // The layout word holds the size code in bits 14 to 10 and the first block in bits 7 to 0.
  // The response word holds the control in bits 1 to 0, busy in bit 2 and the sticky end in bit 4.
  // The counter word holds the packet goal low and the good packets seen so far high.
  // The link status word holds the current FIFO port pipe in bits 3 to 0 and split status in bit 4.
  // Pipe registers read as zero while no pipe is selected, rather than showing stale data.
  // Returning zero between reads lets a wired-or bus merge several register blocks.
  // Register read mux; data stands only in the cycle after the strobe.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd) begin
        case (addr)
          `OFS_PIPE_SELECT:
            rdata <= {12'h000, selected_pipe_index};
          `OFS_PIPE_CONFIG:
            if (sel_ok)
              rdata <= {6'h00, cfg[selected_pipe_index]};
          `OFS_PIPE_LAYOUT:
            if (sel_ok)
              rdata <= {1'h0, size[selected_pipe_index], 2'h0,
                        eff_start(selected_pipe_index, start[selected_pipe_index])};
          `OFS_PIPE_RESPONSE:
            if (sel_ok)
              rdata <= {11'h000, ended[selected_pipe_index], 1'h0,
                        pipe_busy_flag[selected_pipe_index], resp[selected_pipe_index]};
          `OFS_PIPE_TRN:
            if (sel_ok)
              rdata <= {trn_seen[selected_pipe_index], trn_goal[selected_pipe_index]};
          `OFS_LINK_STATUS:
            rdata <= {11'h000, split_control_status, current_pipe_select};
          default:
            rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Engine-side lookup; an index outside one to nine reads as an empty, unused pipe.
  // Its start block is reported even for unused pipes, since software may still be laying them out.
  wire        lk_ok  = is_pipe(link_pipe);
  wire [9:0]  lk_cfg = lk_ok ? cfg[link_pipe] : `RST_CONFIG;
  wire [4:0]  lk_sz  = lk_ok ? size[link_pipe] : `RST_SIZE;
  wire [7:0]  lk_st  = lk_ok ? eff_start(link_pipe, start[link_pipe]) : `RST_START;
  // An absent pipe owns no FIFO bytes, so the one-block size default must not leak out.
  wire [12:0] lk_by  = lk_ok ? fifo_bytes(lk_sz, lk_cfg[`CFG_DBL_BIT]) : `RST_BYTES;

  // Registered view of one pipe for the transfer engine; one cycle of latency.
  // The engine must not rely on the view while it rewrites the same pipe through the registers.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link_dir        <= `DIR_RECEIVE;
      link_endpoint_number_field      <= 4'h0;
      link_in_use     <= 1'h0;
      link_response   <= `RSP_NAK;
      link_fifo_start <= 8'h00;
      link_fifo_last  <= 8'h00;
      link_fifo_bytes <= 13'h0000;
    end else if (ce) begin
      link_dir        <= lk_cfg[`CFG_DIR_BIT];
      link_endpoint_number_field      <= lk_cfg[`CFG_ENDPOINT_NUMBER_FIELD_MSB:`CFG_ENDPOINT_NUMBER_FIELD_LSB];
      link_in_use     <= lk_cfg[`CFG_ENDPOINT_NUMBER_FIELD_MSB:`CFG_ENDPOINT_NUMBER_FIELD_LSB] != 4'h0;
      link_response   <= lk_ok ? resp[link_pipe] : `RSP_NAK;
      link_fifo_start <= lk_st;
      link_fifo_last  <= lk_st + fifo_blocks(lk_sz, lk_cfg[`CFG_DBL_BIT]) - 8'h01;
      link_fifo_bytes <= lk_by;
    end
  end

endmodule // usb_pipe_config

//--- verilog/usb_pipe_config_map.vh
`ifndef USB_PIPE_CONFIG_MAP_VH
`define USB_PIPE_CONFIG_MAP_VH
// Register offsets on the plain register port.
`define OFS_PIPE_SELECT   8'h00
`define OFS_PIPE_CONFIG   8'h02
`define OFS_PIPE_LAYOUT   8'h04
`define OFS_PIPE_RESPONSE 8'h06
`define OFS_PIPE_TRN      8'h08
`define OFS_LINK_STATUS   8'h0a
// Pipe configuration fields.
`define CFG_ENDPOINT_NUMBER_FIELD_LSB     0
`define CFG_ENDPOINT_NUMBER_FIELD_MSB     3
`define CFG_DIR_BIT       4
`define CFG_NAK_EN_BIT    7
`define CFG_TRN_EN_BIT    8
`define CFG_DBL_BIT       9
// FIFO layout fields.
`define LAY_SIZE_LSB      10
`define LAY_SIZE_MSB      14
`define LAY_START_LSB     0
`define LAY_START_MSB     7
`define LAY_START_MIN     8'h04
`define LAY_START_MAX     8'h87
`define FIFO_BLOCK_BYTES  14'h0040
// Response register fields.
`define RSP_CTRL_LSB      0
`define RSP_CTRL_MSB      1
`define RSP_BUSY_BIT      2
`define RSP_ENDED_BIT     4
`define RSP_NAK           2'h0
`define RSP_BUF           2'h1
// Direction codes.
`define DIR_RECEIVE       1'h0
`define DIR_TRANSMIT      1'h1
// Pipe ranges.
`define PIPE_FIRST        4'h1
`define PIPE_LAST_AUTO    4'h5
`define PIPE_FIRST_FIXED  4'h6
`define PIPE_LAST         4'h9
// Reset values.
`define RST_CONFIG        10'h000
`define RST_SIZE          5'h00
`define RST_START         8'h00
`define RST_TRN           8'h00
`define RST_SELECT        4'h0
`define RST_BYTES         13'h0000
// Select and transaction goal fields.
`define SEL_INDEX_LSB     0
`define SEL_INDEX_MSB     3
`define TRN_GOAL_LSB      0
`define TRN_GOAL_MSB      7
`endif

//--- tb/usb_pipe_config_monitor.sv
`timescale 1ns/1ps
`include "usb_pipe_config_map.vh"
module usb_pipe_config_monitor (
  input wire        mclk,
  input wire        nrst,
  input wire        ce,
  input wire [7:0]  addr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire [3:0]  link_pipe,
  input wire        link_in_use,
  input wire [3:0]  link_endpoint_number_field,
  input wire [1:0]  link_response,
  input wire [7:0]  link_fifo_start,
  input wire [7:0]  link_fifo_last,
  input wire [12:0] link_fifo_bytes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // A read is taken where its strobe meets the clock enable.
  sequence rd_at(logic [7:0] a);
    rd && ce && addr == a;
  endsequence
  // Two settled edges keep the zeroed reset tail out of the link checks.
  sequence asked(logic [3:0] lo, logic [3:0] hi);
    $past(nrst, 2) && $past(ce) && $past(link_pipe) >= lo && $past(link_pipe) <= hi;
  endsequence
  AST_IN_USE: assert property (link_in_use == (link_endpoint_number_field != 4'h0))
    else $error("in use flag wrong");
  AST_BYTE_STEP: assert property (link_fifo_bytes[5:0] == 6'h00)
    else $error("fifo bytes off step");
  AST_LAST_BLOCK: assert property (link_fifo_bytes != 13'h0000 |->
    link_fifo_last + 8'h01 == link_fifo_start + {1'b0, link_fifo_bytes[12:6]}) else $error("last block wrong");
  AST_START_RANGE: assert property (link_fifo_start <= `LAY_START_MAX)
    else $error("start block too high");
  AST_FIXED_PIPE: assert property (asked(4'h6, 4'h9) |-> link_fifo_bytes == 13'h0040 &&
    link_fifo_start == {4'h0, $past(link_pipe)} - 8'h02) else $error("fixed pipe layout wrong");
  AST_NO_PIPE: assert property (asked(4'h0, 4'h0) |-> link_fifo_bytes == 13'h0000 &&
    link_response == `RSP_NAK && !link_in_use) else $error("no pipe not zero");
  AST_LAYOUT_GAPS: assert property (rd_at(`OFS_PIPE_LAYOUT) |=> rdata[15] == 1'b0 && rdata[9:8] == 2'h0)
    else $error("layout gap bits set");
  AST_RDATA_IDLE: assert property (ce && !rd |=> rdata == 16'h0000)
    else $error("read data outside read");
endmodule // usb_pipe_config_monitor
bind usb_pipe_config usb_pipe_config_monitor u_mon (.mclk, .nrst, .ce, .addr, .rd, .rdata, .link_pipe,
  .link_in_use, .link_endpoint_number_field, .link_response, .link_fifo_start, .link_fifo_last, .link_fifo_bytes);

//--- tb/usb_link_partner.sv
`timescale 1ns/1ps
module usb_link_partner (
  input  wire       mclk,
  output reg        rx_done = 1'b0,
  output reg  [3:0] rx_pipe = 4'h0,
  output reg        rx_ok = 1'b0,
  output reg        rx_short = 1'b0,
  output reg  [3:0] link_pipe = 4'h0
);
  // One packet; the qualifiers flip afterwards so a stale value never looks valid.
  task packet(input [3:0] p, input ok, input sh);
    @(posedge mclk);
    rx_done <= 1'b1;
    {rx_pipe, rx_ok, rx_short} <= {p, ok, sh};
    @(posedge mclk);
    rx_done <= 1'b0;
    {rx_pipe, rx_ok, rx_short} <= ~{p, ok, sh};
  endtask
  // The engine asks about a pipe; the answer has settled one edge later.
  task ask(input [3:0] p);
    @(posedge mclk);
    link_pipe <= p;
    @(posedge mclk);
    #1;
  endtask
endmodule // usb_link_partner

//--- tb/tb_usb_pipe_config.sv
`timescale 1ns/1ps
`include "usb_pipe_config_map.vh"
module tb_usb_pipe_config;
  reg         mclk, nrst, wr, rd;
  reg         ce, split_control_status;
  reg  [3:0]  current_pipe_select;
  reg  [9:0]  pipe_busy_flag;
  reg  [7:0]  addr;
  reg  [15:0] wdata;
  wire [15:0] rdata;
  wire        rx_done, rx_ok, rx_short, link_dir, link_in_use;
  wire [3:0]  rx_pipe, link_pipe, link_endpoint_number_field;
  wire [1:0]  link_response;
  wire [7:0]  link_fifo_start, link_fifo_last;
  wire [12:0] link_fifo_bytes;
  integer     fails, n_compared;
  localparam [7:0] SEL = `OFS_PIPE_SELECT, CFG = `OFS_PIPE_CONFIG, LAY = `OFS_PIPE_LAYOUT, RSP = `OFS_PIPE_RESPONSE;
  // Link-side levels are driven by the bench so that their read-back paths are exercised.
  usb_pipe_config u_dut (.mclk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .rx_done, .rx_pipe, .rx_ok,
    .rx_short, .pipe_busy_flag, .split_control_status, .current_pipe_select, .link_pipe,
    .link_dir, .link_endpoint_number_field, .link_in_use, .link_response, .link_fifo_start, .link_fifo_last, .link_fifo_bytes);
  usb_link_partner u_far (.mclk, .rx_done, .rx_pipe, .rx_ok, .rx_short, .link_pipe);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task chk(input string what, input [15:0] exp, input [15:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes rise after an edge and drop after the edge that takes them.
  task w(input [7:0] a, input [15:0] d);
    @(posedge mclk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task r(input string what, input [7:0] a, input [15:0] exp);
    @(posedge mclk);
    {rd, addr} <= {1'b1, a};
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask
  // Pipe 3: loose bits drop, a start below the first block is ignored, doubling doubles the span.
  task s_layout;
    w(SEL, 16'h0003);
    r("layout", LAY, 16'h0000);
    w(LAY, 16'hff87);
    w(LAY, 16'h7c03);
    r("layout", LAY, 16'h7c87);
    w(CFG, 16'h0203);
    u_far.ask(4'h3);
    chk("bytes", 16'h1000, {3'h0, link_fifo_bytes});
    chk("last", 16'h00c6, {8'h00, link_fifo_last});
    r("unmapped", 8'h0c, 16'h0000);
  endtask
  // Pipe 6: upper options forced off, first block fixed, no NAK of its own.
  task s_fixed;
    w(SEL, 16'h0006);
    w(CFG, 16'h0386);
    r("config", CFG, 16'h0006);
    u_far.ask(4'h6);
    chk("start", 16'h0004, {8'h00, link_fifo_start});
    w(RSP, 16'h0001);
    u_far.packet(4'h6, 1'b1, 1'b1);
    r("response", RSP, 16'h0011);
  endtask
  // Pipe 4 transmits, so a short packet aimed at it ends nothing.
  task s_dir;
    w(SEL, 16'h0004);
    r("layout", LAY, 16'h0000);
    w(CFG, 16'h0014);
    w(RSP, 16'h0001);
    u_far.packet(4'h4, 1'b1, 1'b1);
    r("response", RSP, 16'h0005);
    u_far.ask(4'h4);
    chk("link", 16'h0034, {10'h000, link_in_use, link_dir, link_endpoint_number_field});
  endtask
  // Pipe 1: full or errored packets keep it open; a good short one or the counted packets close it.
  task s_nak;
    w(SEL, 16'h0001);
    w(CFG, 16'h0081);
    w(RSP, 16'h0001);
    u_far.packet(4'h1, 1'b1, 1'b0);
    u_far.packet(4'h1, 1'b0, 1'b1);
    r("response", RSP, 16'h0001);
    u_far.packet(4'h1, 1'b1, 1'b1);
    r("response", RSP, 16'h0010);
    w(RSP, 16'h0010);
    w(CFG, 16'h0181);
    w(`OFS_PIPE_TRN, 16'h0002);
    w(RSP, 16'h0001);
    u_far.packet(4'h1, 1'b1, 1'b0);
    r("response", RSP, 16'h0001);
    r("count", `OFS_PIPE_TRN, 16'h0102);
    u_far.packet(4'h1, 1'b1, 1'b0);
    u_far.ask(4'h1);
    chk("link response", 16'h0000, {14'h0000, link_response});
  endtask
  // Read-back levels, busy of the selected pipe, and a write made while the clock enable is low.
  task s_status;
    @(posedge mclk);
    {split_control_status, current_pipe_select, pipe_busy_flag} <= {1'b1, 4'h5, 10'h002};
    r("link status", `OFS_LINK_STATUS, 16'h0015);
    r("response", RSP, 16'h0014);
    @(posedge mclk);
    ce <= 1'b0;
    w(SEL, 16'h0002);
    ce <= 1'b1;
    r("frozen select", SEL, 16'h0001);
  endtask
  task wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {fails, n_compared} = {32'h0, 32'h0};
    {nrst, wr, rd, addr, wdata} = {3'h0, 8'h00, 16'h0000};
    // Only pipe 4 reports busy at first, and pipe 9, which no scenario touches, owns the FIFO port.
    {ce, split_control_status, current_pipe_select, pipe_busy_flag} = {1'b1, 1'b0, 4'h9, 10'h010};
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    s_layout;
    s_fixed;
    s_dir;
    s_nak;
    s_status;
    wrap_up;
  end
  // The sequence needs about a hundred cycles; a hang past 4000 is cut short.
  initial begin
    #20000;
    fails = fails + 1;
    wrap_up;
  end
endmodule // tb_usb_pipe_config
